// ==== common/lvcfg_params.svh ====
// Constants of the LVDS output configuration register group.
// Assumes inclusion by bare name from lvcfg_regs, the only module that includes it.
// How it works
// R1 - Level bit 6 picks common-mode level
// R2 - Software sets trim 01 with low level
// R3 - Swing field bits 3-2, reset 01
// R4 - Reserved bits read zero, writes ignored
// R5 - Order bit 5 reverses output pin order
// R6 - Reverse swaps lanes 0/3, lane 1/clock
// R7 - Order bit 1 picks termination, reset high
// R8 - Termination and swing form one drive code
// R9 - Trim field bits 5-4 adjusts common mode
// R10 - Low byte of 12-bit line length
// R11 - Line length to A, or A and B
// R12 - Pattern-only values act only in pattern mode
// R13 - Next register bits 3-0 hold upper nibble
`ifndef LVCFG_PARAMS_SVH
`define LVCFG_PARAMS_SVH

// Register indices; byte address is four times the index
`define LVCFG_IDX_LEVEL 8'h19
`define LVCFG_IDX_ORDER 8'h1a
`define LVCFG_IDX_TRIM 8'h1b
`define LVCFG_IDX_LENLO 8'h20
`define LVCFG_IDX_LENHI 8'h21
`define LVCFG_IDX_MODE 8'h30
`define LVCFG_IDX_STAT 8'h31

// Address slicing of haddr
`define LVCFG_IDX_LSB 2
`define LVCFG_IDX_MSB 9
`define LVCFG_IDX_W 8

// Field positions
`define LVCFG_VOCM_BIT 6
`define LVCFG_SWING_LSB 2
`define LVCFG_FLIP_BIT 5
`define LVCFG_TERM_BIT 1
`define LVCFG_TRIM_LSB 4
`define LVCFG_LENLO_LSB 0
`define LVCFG_LENHI_LSB 0
`define LVCFG_SINGLE_BIT 0
`define LVCFG_TPEN_BIT 1
`define LVCFG_STAT_LEN_LSB 0
`define LVCFG_STAT_FLIP_BIT 12
`define LVCFG_STAT_CHB_BIT 13

// Reset values
`define LVCFG_RST_VOCM 1'b0
`define LVCFG_RST_SWING 2'b01
`define LVCFG_RST_FLIP 1'b0
`define LVCFG_RST_TERM 1'b1
`define LVCFG_RST_TRIM 2'b00
`define LVCFG_RST_LENLO 8'h00
`define LVCFG_RST_LENHI 4'h0
`define LVCFG_RST_SINGLE 1'b1
`define LVCFG_RST_TPEN 1'b0

// Bus constants
`define LVCFG_HTRANS_ACT_BIT 1
`define LVCFG_HRESP_OKAY 1'b0

`endif

// ==== common/lvcfg_pkg.sv ====
// Types shared by the LVDS output configuration block.
// Assumes the constants header sits beside it.
package lvcfg_pkg;

  // Bus handler states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WR = 4'b0010,
    S_RDWAIT = 4'b0100,
    S_RDOUT = 4'b1000
  } lvcfg_state_e;

  // Common-mode trim codes
  typedef enum logic [1:0] {
    TRIM_NONE = 2'b00,
    TRIM_DOWN3 = 2'b01,
    TRIM_UP3 = 2'b10,
    TRIM_UP6 = 2'b11
  } lvcfg_trim_e;

  // One bit per LVDS output pin of the channel
  typedef struct packed {
    logic outLane0Pos;
    logic outLane0Neg;
    logic outLane1Pos;
    logic outLane1Neg;
    logic outLane2Pos;
    logic outLane2Neg;
    logic outLane3Pos;
    logic outLane3Neg;
    logic outClockLanePos;
    logic outClockLaneNeg;
  } lvcfg_lanes_s;

  // Settings for the analog output driver
  typedef struct packed {
    logic cmLow;
    logic [1:0] swing;
    logic termHigh;
    lvcfg_trim_e trim;
    logic [2:0] driveCode;
  } lvcfg_analog_s;

endpackage : lvcfg_pkg

// ==== core/lvcfg_field_reg.sv ====
// One software-writable register field with its own reset value.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/10ps
module lvcfg_field_reg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import lvcfg_pkg::*;

  // Store on write, reset to field default
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= RST;
    else if (we)
      q <= d;
  end

endmodule : lvcfg_field_reg

// ==== core/lvcfg_lane_mux.sv ====
// Output pin order selector for the LVDS channel, registered.
// Assumes lane bits come from the serializer on the same clock.
`timescale 1ns/10ps
module lvcfg_lane_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flip,
  input wire lvcfg_pkg::lvcfg_lanes_s lanesIn,
  output lvcfg_pkg::lvcfg_lanes_s lanesOut
);
  import lvcfg_pkg::*;

  lvcfg_lanes_s swapped; // Reversed pin order view

  // Lane 0 with lane 3, lane 1 with clock, lane 2 stays
  assign swapped.outLane0Pos = lanesIn.outLane3Pos; // R6
  assign swapped.outLane0Neg = lanesIn.outLane3Neg; // R6
  assign swapped.outLane3Pos = lanesIn.outLane0Pos; // R6
  assign swapped.outLane3Neg = lanesIn.outLane0Neg; // R6
  assign swapped.outLane1Pos = lanesIn.outClockLanePos; // R6
  assign swapped.outLane1Neg = lanesIn.outClockLaneNeg; // R6
  assign swapped.outClockLanePos = lanesIn.outLane1Pos; // R6
  assign swapped.outClockLaneNeg = lanesIn.outLane1Neg; // R6
  assign swapped.outLane2Pos = lanesIn.outLane2Pos;
  assign swapped.outLane2Neg = lanesIn.outLane2Neg;

  // Pick normal or reversed order each clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lanesOut <= '0;
    else
      lanesOut <= flip ? swapped : lanesIn; // R5
  end

endmodule : lvcfg_lane_mux

// ==== core/lvcfg_regs.sv ====
// AHB-Lite register group for the LVDS output channel settings.
// Holds levels, swing, termination, trim, pin order and line length.
// Reads take one wait state, writes none; the response is always OKAY.
// Lane data passes one register stage with optional pin reversal.
// Assumes a single AHB-Lite master and lane data on the same clock.
`timescale 1ns/10ps
`include "lvcfg_params.svh"
module lvcfg_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire lvcfg_pkg::lvcfg_lanes_s lanesIn,
  output lvcfg_pkg::lvcfg_lanes_s lanesOut,
  output lvcfg_pkg::lvcfg_analog_s analogCfg,
  output logic [11:0] chALineLen,
  output logic [11:0] chBLineLen,
  output logic chBEnable,
  output logic [11:0] patternLineLen,
  output logic patternEnable
);
  import lvcfg_pkg::*;

  // Bus handler state
  lvcfg_state_e state_r; // Current phase of the transfer
  lvcfg_state_e state_nxt; // Next phase
  logic [`LVCFG_IDX_W-1:0] idx_r; // Latched register index
  logic inRange_r; // Latched address is word aligned inside the index window
  logic hreadyout_r; // Ready back to the master
  logic [31:0] hrdata_r; // Read data register
  logic hresp_r; // Response, always OKAY

  // Field storage outputs
  logic cmLow; // Lower common-mode level chosen
  logic [1:0] swing; // Differential swing code
  logic pinFlip; // Reversed pin order chosen
  logic termHigh; // Higher termination chosen
  logic [1:0] trim; // Common-mode trim code
  logic [7:0] lenLo; // Line length low byte
  logic [3:0] lenHi; // Line length high nibble
  logic singleChan; // Single output channel mode
  logic tpEn; // Test pattern generation enable

  // Derived output registers
  lvcfg_analog_s analog_r; // Driver settings
  logic [11:0] chALen_r; // Channel A line length
  logic [11:0] chBLen_r; // Channel B line length
  logic chBEn_r; // Channel B in use
  logic [11:0] patLen_r; // Pattern generator line length
  logic patEn_r; // Pattern generator enable

  // The bus is pipelined: the address phase is latched here and the
  // register is touched one cycle later, in the data phase.
  // Only the index bits are kept; high and low address bits must be
  // zero, otherwise the access counts as unmapped.
  // Address phase decode
  wire accept = hsel && htrans[`LVCFG_HTRANS_ACT_BIT] && hready;
  wire addrOk = (haddr[31:`LVCFG_IDX_MSB+1] == '0) && (haddr[`LVCFG_IDX_LSB-1:0] == '0);

  // Register select from the latched index
  wire selLevel = inRange_r && (idx_r == `LVCFG_IDX_LEVEL);
  wire selOrder = inRange_r && (idx_r == `LVCFG_IDX_ORDER);
  wire selTrim = inRange_r && (idx_r == `LVCFG_IDX_TRIM);
  wire selLenLo = inRange_r && (idx_r == `LVCFG_IDX_LENLO);
  wire selLenHi = inRange_r && (idx_r == `LVCFG_IDX_LENHI);
  wire selMode = inRange_r && (idx_r == `LVCFG_IDX_MODE);
  wire selStat = inRange_r && (idx_r == `LVCFG_IDX_STAT);

  // Write strobes in the write data phase
  wire wrPhase = (state_r == S_WR);
  wire weLevel = wrPhase && selLevel;
  wire weOrder = wrPhase && selOrder;
  wire weTrim = wrPhase && selTrim;
  wire weLenLo = wrPhase && selLenLo;
  wire weLenHi = wrPhase && selLenHi;
  wire weMode = wrPhase && selMode;

  // Full twelve-bit active line length
  wire [11:0] lineLen = {lenHi, lenLo}; // R10 R13

  // Reads insert one wait state so the read word comes from settled
  // field values, never from a write landing in the same cycle.
  // Writes complete with no wait state.
  // Next bus phase
  always_comb
  begin
    case (state_r)
      S_IDLE, S_WR, S_RDOUT:
      begin
        if (accept)
          state_nxt = hwrite ? S_WR : S_RDWAIT;
        else
          state_nxt = S_IDLE;
      end
      S_RDWAIT:
        state_nxt = S_RDOUT;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // The address is only sampled while ready is high, so a master that
  // holds its address through the wait state is not taken twice.
  // Bus state, address latch, ready and response
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      idx_r <= '0;
      inRange_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r <= `LVCFG_HRESP_OKAY;
    end
    else
    begin
      state_r <= state_nxt;
      hreadyout_r <= (state_nxt != S_RDWAIT);
      hresp_r <= `LVCFG_HRESP_OKAY;
      if (accept)
      begin
        idx_r <= haddr[`LVCFG_IDX_MSB:`LVCFG_IDX_LSB];
        inRange_r <= addrOk;
      end
    end
  end

  // Each field keeps its own reset value; reserved positions have no
  // storage at all, so whatever lands on them vanishes.
  // Common-mode level select
  lvcfg_field_reg #(.W(1), .RST(`LVCFG_RST_VOCM)) uVocm (
    .clk(clk), .rst_n(rst_n), .we(weLevel),
    .d(hwdata[`LVCFG_VOCM_BIT]), .q(cmLow) // R1
  );

  // Differential swing select
  lvcfg_field_reg #(.W(2), .RST(`LVCFG_RST_SWING)) uSwing (
    .clk(clk), .rst_n(rst_n), .we(weLevel),
    .d(hwdata[`LVCFG_SWING_LSB +: 2]), .q(swing) // R3
  );

  // Pin order flip
  lvcfg_field_reg #(.W(1), .RST(`LVCFG_RST_FLIP)) uFlip (
    .clk(clk), .rst_n(rst_n), .we(weOrder),
    .d(hwdata[`LVCFG_FLIP_BIT]), .q(pinFlip) // R5
  );

  // Near-end termination select
  lvcfg_field_reg #(.W(1), .RST(`LVCFG_RST_TERM)) uTerm (
    .clk(clk), .rst_n(rst_n), .we(weOrder),
    .d(hwdata[`LVCFG_TERM_BIT]), .q(termHigh) // R7
  );

  // Common-mode trim
  lvcfg_field_reg #(.W(2), .RST(`LVCFG_RST_TRIM)) uTrim (
    .clk(clk), .rst_n(rst_n), .we(weTrim),
    .d(hwdata[`LVCFG_TRIM_LSB +: 2]), .q(trim) // R9
  );

  // Line length low byte
  lvcfg_field_reg #(.W(8), .RST(`LVCFG_RST_LENLO)) uLenLo (
    .clk(clk), .rst_n(rst_n), .we(weLenLo),
    .d(hwdata[`LVCFG_LENLO_LSB +: 8]), .q(lenLo) // R10
  );

  // Line length high nibble
  lvcfg_field_reg #(.W(4), .RST(`LVCFG_RST_LENHI)) uLenHi (
    .clk(clk), .rst_n(rst_n), .we(weLenHi),
    .d(hwdata[`LVCFG_LENHI_LSB +: 4]), .q(lenHi) // R13
  );

  // Single-channel mode bit
  lvcfg_field_reg #(.W(1), .RST(`LVCFG_RST_SINGLE)) uSingle (
    .clk(clk), .rst_n(rst_n), .we(weMode),
    .d(hwdata[`LVCFG_SINGLE_BIT]), .q(singleChan)
  );

  // Test pattern enable bit
  lvcfg_field_reg #(.W(1), .RST(`LVCFG_RST_TPEN)) uTpEn (
    .clk(clk), .rst_n(rst_n), .we(weMode),
    .d(hwdata[`LVCFG_TPEN_BIT]), .q(tpEn)
  );

  // Zero in reserved and unmapped places lets software compare a
  // read-back word directly with the value it wrote.
  // Read word assembly; reserved and unmapped bits read zero
  logic [31:0] rdWord; // Word for the selected register
  always_comb
  begin
    rdWord = '0; // R4
    if (selLevel)
    begin
      rdWord[`LVCFG_VOCM_BIT] = cmLow;
      rdWord[`LVCFG_SWING_LSB +: 2] = swing;
    end
    else if (selOrder)
    begin
      rdWord[`LVCFG_FLIP_BIT] = pinFlip;
      rdWord[`LVCFG_TERM_BIT] = termHigh;
    end
    else if (selTrim)
      rdWord[`LVCFG_TRIM_LSB +: 2] = trim;
    else if (selLenLo)
      rdWord[`LVCFG_LENLO_LSB +: 8] = lenLo;
    else if (selLenHi)
      rdWord[`LVCFG_LENHI_LSB +: 4] = lenHi;
    else if (selMode)
    begin
      rdWord[`LVCFG_SINGLE_BIT] = singleChan;
      rdWord[`LVCFG_TPEN_BIT] = tpEn;
    end
    else if (selStat)
    begin
      rdWord[`LVCFG_STAT_LEN_LSB +: 12] = chALen_r;
      rdWord[`LVCFG_STAT_FLIP_BIT] = pinFlip;
      rdWord[`LVCFG_STAT_CHB_BIT] = chBEn_r;
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata_r <= '0;
    else if (state_r == S_RDWAIT)
      hrdata_r <= rdWord;
  end

  // The analog cells take their settings one clock after a field
  // changes; a clean registered update matters more than latency.
  // Low common mode needs the matching trim code; hardware does not
  // enforce it, so the driver software has to.
  // Driver settings; termination and swing act as one code
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      analog_r <= '{cmLow: `LVCFG_RST_VOCM, swing: `LVCFG_RST_SWING,
                    termHigh: `LVCFG_RST_TERM, trim: TRIM_NONE,
                    driveCode: {`LVCFG_RST_TERM, `LVCFG_RST_SWING}};
    else
    begin
      analog_r.cmLow <= cmLow; // R1
      analog_r.swing <= swing; // R3
      analog_r.termHigh <= termHigh; // R7
      analog_r.trim <= lvcfg_trim_e'(trim); // R9
      analog_r.driveCode <= {termHigh, swing}; // R8
    end
  end

  // Channel B follows the line length only in dual-channel mode; in
  // single mode it is held at zero so an idle channel sees no length.
  // The pattern generator sees the length only while it is enabled.
  // Line length routing to channels and pattern generator
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chALen_r <= '0;
      chBLen_r <= '0;
      chBEn_r <= 1'b0;
      patLen_r <= '0;
      patEn_r <= 1'b0;
    end
    else
    begin
      chALen_r <= lineLen; // R11
      chBLen_r <= singleChan ? '0 : lineLen; // R11
      chBEn_r <= !singleChan; // R11
      patLen_r <= tpEn ? lineLen : '0; // R12
      patEn_r <= tpEn; // R12
    end
  end

  // The pin order stage adds one clock of latency to every lane.
  // Output pin order stage
  lvcfg_lane_mux uLaneMux (
    .clk(clk),
    .rst_n(rst_n),
    .flip(pinFlip),
    .lanesIn(lanesIn),
    .lanesOut(lanesOut)
  );

  // No output passes through logic after its flip-flop.
  // Port drive from registers
  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign analogCfg = analog_r;
  assign chALineLen = chALen_r;
  assign chBLineLen = chBLen_r;
  assign chBEnable = chBEn_r;
  assign patternLineLen = patLen_r;
  assign patternEnable = patEn_r;

endmodule : lvcfg_regs

// ==== sim/lvcfg_panel_model.sv ====
// Display panel sink that latches the channel pins every clock.
// Assumes lanes come from the register group on the same clock.
`timescale 1ns/10ps
module lvcfg_panel_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire lvcfg_pkg::lvcfg_lanes_s lanes,
  output lvcfg_pkg::lvcfg_lanes_s rxLanes
);
  import lvcfg_pkg::*;
  // Receiver latch, cleared in reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rxLanes <= '0;
    else
      rxLanes <= lanes;
  end
endmodule : lvcfg_panel_model

// ==== sim/lvcfg_chk.sv ====
// Concurrent checks on the ports of the LVDS register group.
// Assumes hready is tied to hreadyout by the surrounding bench.
`timescale 1ns/10ps
module lvcfg_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire lvcfg_pkg::lvcfg_lanes_s lanesIn,
  input wire lvcfg_pkg::lvcfg_lanes_s lanesOut,
  input wire lvcfg_pkg::lvcfg_analog_s analogCfg,
  input wire logic [11:0] chALineLen,
  input wire logic [11:0] chBLineLen,
  input wire logic chBEnable,
  input wire logic [11:0] patternLineLen,
  input wire logic patternEnable
);
  import lvcfg_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Reversed pin order of one lane word
  function automatic lvcfg_lanes_s flp(lvcfg_lanes_s x);
    return {x[3:2], x[1:0], x[5:4], x[9:8], x[7:6]};
  endfunction : flp
  // Bus steps
  sequence rdTaken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence wrTaken;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence rdAnswer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (rdTaken |=> rdAnswer)
    else $error("read wait state wrong");
  a_write_ready: assert property (wrTaken |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_lane_keep: assert property ($past(rst_n) |-> lanesOut[5:4] == $past(lanesIn[5:4]))
    else $error("middle lane moved");
  a_lane_map: assert property ($past(rst_n) |->
    (lanesOut == $past(lanesIn) || lanesOut == flp($past(lanesIn))))
    else $error("lane order wrong");
  a_drive_code: assert property (analogCfg.driveCode == {analogCfg.termHigh, analogCfg.swing})
    else $error("drive code mismatch");
  a_chb_gate: assert property (!chBEnable |-> chBLineLen == 12'h000)
    else $error("channel B length while off");
  a_chb_copy: assert property (chBEnable |-> chBLineLen == chALineLen)
    else $error("channel B length differs");
  a_pat_gate: assert property (!patternEnable |-> patternLineLen == 12'h000)
    else $error("pattern length while off");
  a_pat_copy: assert property (patternEnable |-> patternLineLen == chALineLen)
    else $error("pattern length differs");
  a_reset_vals: assert property ($rose(rst_n) |->
    analogCfg == 9'h065 && chALineLen == 12'h000)
    else $error("reset values wrong");
endmodule : lvcfg_chk
bind lvcfg_regs lvcfg_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .lanesIn(lanesIn), .lanesOut(lanesOut), .analogCfg(analogCfg), .chALineLen(chALineLen),
  .chBLineLen(chBLineLen), .chBEnable(chBEnable), .patternLineLen(patternLineLen),
  .patternEnable(patternEnable));

// ==== sim/tb_top.sv ====
// Self-checking bench for the LVDS register group with a bus master.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import lvcfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, chBEnable, patternEnable;
  logic [31:0] hrdata, rd, d;
  lvcfg_lanes_s lanesIn = '0;
  lvcfg_lanes_s lanesOut, rxLanes;
  lvcfg_analog_s analogCfg;
  logic [11:0] chALineLen, chBLineLen, patternLineLen;
  int errTotal = 0;
  int checks = 0;
  int i;
  logic [31:0] seed = 32'h000177d7;
  // Register byte addresses, writable masks and reference contents
  int adr[6] = '{8'h64, 8'h68, 8'h6c, 8'h80, 8'h84, 8'hc0};
  int msk[6] = '{8'h4c, 8'h22, 8'h30, 8'hff, 8'h0f, 8'h03};
  int mdl[6] = '{8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
  lvcfg_regs DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lanesIn(lanesIn),
    .lanesOut(lanesOut), .analogCfg(analogCfg), .chALineLen(chALineLen),
    .chBLineLen(chBLineLen), .chBEnable(chBEnable), .patternLineLen(patternLineLen),
    .patternEnable(patternEnable));
  lvcfg_panel_model panel (.clk(clk), .rst_n(rst_n), .lanes(lanesOut), .rxLanes(rxLanes));
  // Free-running clock, 50 ns period
  initial forever #25 clk = ~clk;
  // Pseudo-random source
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Expected reversed pin order
  function automatic lvcfg_lanes_s flp(logic [9:0] x);
    return {x[3:2], x[1:0], x[5:4], x[9:8], x[7:6]};
  endfunction : flp
  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 16)
    begin
      errTotal++;
      complete_run();
    end
  endtask : wait_ready
  // One single-word transfer; read data lands in rd
  task automatic bus_xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus_xfer
  // Write only the writable bits of a register; track it in the reference
  task automatic wr(input int k, input logic [31:0] wd);
    bus_xfer(1'b1, adr[k], wd & msk[k]);
    mdl[k] = wd & msk[k];
  endtask : wr
  // Read every writable register and one unmapped place
  task automatic read_all();
    for (int k = 0; k < 6; k++)
    begin
      bus_xfer(1'b0, adr[k], rnd());
      `CHK(rd, 32'(mdl[k]))
    end
    bus_xfer(1'b0, 32'h100, rnd());
    `CHK(rd, 32'h0)
  endtask : read_all
  // Compare derived outputs and status with the reference
  task automatic check_outs();
    logic [11:0] len;
    logic [8:0] ea;
    repeat (2) @(posedge clk);
    len = {mdl[4][3:0], mdl[3][7:0]};
    ea = {mdl[0][6], mdl[0][3:2], mdl[1][1], mdl[2][5:4], mdl[1][1], mdl[0][3:2]};
    `CHK(analogCfg, ea)
    `CHK(chALineLen, len)
    `CHK(chBEnable, ~mdl[5][0])
    `CHK(chBLineLen, mdl[5][0] ? 12'h000 : len)
    `CHK(patternEnable, mdl[5][1])
    `CHK(patternLineLen, mdl[5][1] ? len : 12'h000)
    bus_xfer(1'b0, 32'hc4, 32'h0);
    `CHK(rd, {18'h0, ~mdl[5][0], mdl[1][5], len})
  endtask : check_outs
  // Verdict and end of run
  task complete_run();
    $display("checks=%0d mismatches=%0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    read_all();
    check_outs();
    $display("test reset done");
    // Every swing, trim and mode code
    for (int c = 0; c < 4; c++)
    begin
      wr(0, c << 2);
      wr(2, c << 4);
      wr(1, (c & 1) << 1);
      wr(5, c);
      wr(3, rnd());
      wr(4, rnd());
      check_outs();
    end
    wr(2, 32'h10);
    wr(0, 32'h44);
    check_outs();
    $display("test codes done");
    // Random writes and an unmapped write
    repeat (24)
    begin
      i = rnd() % 6;
      d = rnd();
      if (i == 0) d[6] = 1'b0;
      if (i == 2 && mdl[0][6]) d[5:4] = 2'b01;
      wr(i, d);
      bus_xfer(1'b1, 32'h1f0, rnd());
      read_all();
      check_outs();
    end
    $display("test random done");
    // Reset in mid-run; every field back to its default
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mdl = '{8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
    read_all();
    check_outs();
    $display("test mid reset done");
    // Pin order through the panel, normal then reversed
    for (int f = 0; f < 2; f++)
    begin
      wr(1, (f << 5) | 2);
      repeat (4)
      begin
        d = rnd();
        lanesIn <= d[9:0];
        repeat (4) @(posedge clk);
        `CHK(rxLanes, f ? flp(d[9:0]) : lvcfg_lanes_s'(d[9:0]))
      end
    end
    $display("test lanes done");
    complete_run();
  end
endmodule : tb_top
